// File: hdl/mq_consts.svh
`ifndef MQ_CONSTS_SVH
`define MQ_CONSTS_SVH

// apb register byte offsets
`define MQ_REG_CTRL 8'h00
`define MQ_REG_STATUS 8'h04

// control register fields
`define MQ_CTRL_DONE_BIT 0
`define MQ_CTRL_ID_LSB 1
`define MQ_CTRL_QCNT_LSB 4
`define MQ_CTRL_RESET 32'h0000_0000

// queue counts and address fields
`define MQ_QCNT_64 8'h40
`define MQ_QCNT_128 8'h80
`define MQ_Q_MSB 6
`define MQ_DEV_LSB 5
`define MQ_WORD_MSB 1

// first word fall through latency in read clock edges
`define MQ_FALL_EDGES 2'h2

// packet marker positions on the output bus
`define MQ_SOP_BIT 32
`define MQ_EOP_BIT 33

`endif

// File: hdl/mq_pkg.sv
package mq_pkg;

    // head word of the selected queue as offered by the queue core
    typedef struct packed {
        logic [35:0] head_data;
        logic head_sop;
        logic head_eop;
        logic head_valid;
        logic pkt_ready;
        logic almost_empty;
    } mq_core_t;

    // mode straps sampled at master reset
    typedef struct packed {
        logic pkt_mode;
        logic direct_mode;
        logic [1:0] qsel;
    } mq_straps_t;

endpackage

// File: hdl/mq_flag_bus.sv
`timescale 1ns/1ns
`default_nettype none
`include "mq_consts.svh"

module mq_flag_bus
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mrs_active,
    input wire logic direct_mode,
    input wire logic pkt_mode,
    input wire logic empty_flag_strobe,
    input wire logic [7:0] read_address_bus,
    input wire logic [2:0] device_id,
    input wire logic [127:0] pr_vec,
    input wire logic [127:0] pae_vec,
    output logic [7:0] read_flag_status_bus,
    output logic flag_bus_oe,
    output logic empty_flag_sync
);
    import mq_pkg::*;

    logic [1:0] word_idx;
    logic [1:0] next_word_idx;
    logic dev_hit;
    logic next_dev_hit;
    logic [7:0] next_flags;
    logic next_sync;
    logic [127:0] flag_vec;

    // status source follows the packet strap
    assign flag_vec = pkt_mode ? pr_vec : pae_vec;

    // word pointer: strobed choice in direct mode, free cycling in polled mode
    always_comb
    begin
        next_word_idx = word_idx;
        next_dev_hit = dev_hit;
        if (mrs_active)
        begin
            next_word_idx = 2'h0;
            next_dev_hit = 1'b0;
        end
        else if (direct_mode)
        begin
            if (empty_flag_strobe)
            begin
                next_word_idx = read_address_bus[`MQ_WORD_MSB:0];
                next_dev_hit = read_address_bus[7:`MQ_DEV_LSB] == device_id;
            end
        end
        else
        begin
            next_word_idx = word_idx + 2'h1;
            next_dev_hit = 1'b1;
        end
        // bus lines are active low, like the discrete flags, so FF means nothing flagged
        next_flags = ~flag_vec[{next_word_idx, 3'h0} +: 8];
        next_sync = !direct_mode && !mrs_active && next_word_idx == 2'h0;
    end

    // register the bus, its enable and the sync marker
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_idx <= 2'h0;
            dev_hit <= 1'b0;
            read_flag_status_bus <= 8'hFF;
            empty_flag_sync <= 1'b0;
        end
        else
        begin
            word_idx <= next_word_idx;
            dev_hit <= next_dev_hit;
            read_flag_status_bus <= next_flags;
            empty_flag_sync <= next_sync;
        end
    end

    assign flag_bus_oe = dev_hit;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_poll_cycle_step: assert property (!direct_mode && !mrs_active |=>
        word_idx == $past(word_idx) + 2'h1)
        else $error("polled flag word did not advance");
    a_strobe_word_pick: assert property (direct_mode && !mrs_active && empty_flag_strobe
        |=> word_idx == $past(read_address_bus[1:0]))
        else $error("strobed status word not latched");
    c_poll_wrap: cover property (empty_flag_sync ##4 empty_flag_sync);

endmodule
`default_nettype wire

// File: hdl/mq_read_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "mq_consts.svh"

// Operation
// - packet ready flag low while selected queue holds a complete packet
// - packet mode chosen at master reset from strap, held until next one
// - packet readable only when packet ready and output ready both asserted
// - read word given on clock edge only with read enable and chip select low, selected; code also fetches one without them while no word is held
// - in packet mode top four output bits may carry packet markers
// - queue config select: 00 write bus, 01 read bus, 10 64, 11 128; code takes 00 from the control register count field
// - read address latched as new queue on edge with address enable high
// - flags synchronous to read clock; polled bus and sync cycle on it
// - direct mode picks status word on edge using strobe and address
// - output enabled only when chip select and output enable agree
// - low seven address bits pick queue, top three bits pick device
// - new queue's first word appears two edges after select, ignoring read enable
// - status word index from low two bits, device from top three
// - fall through mode accepts queue select whatever read enable
// - flag bus cycling and word selection need no read enable
// - strap high gives packet mode, low almost empty mode with inactive flag
// - flag mode strap at master reset picks direct or polled flag bus
module mq_read_port
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_reset_n,
    input wire logic packet_mode_strap,
    input wire logic flag_mode_strap,
    input wire logic [1:0] queue_config_select,
    input wire logic read_addr_enable,
    input wire logic [7:0] read_address_bus,
    input wire logic read_enable_n,
    input wire logic read_chip_select_n,
    input wire logic output_enable_n,
    input wire logic empty_flag_strobe,
    input wire mq_pkg::mq_core_t core,
    input wire logic [127:0] pr_vec,
    input wire logic [127:0] pae_vec,
    output logic [6:0] core_queue,
    output logic core_pop,
    output logic [35:0] q_data,
    output logic q_oe,
    output logic read_side_empty_n,
    output logic packet_ready_flag_n,
    output logic almost_empty_flag_n,
    output logic packet_available,
    output logic serial_done_out_n,
    output logic [7:0] read_flag_status_bus,
    output logic flag_bus_oe,
    output logic empty_flag_sync
);
    import mq_pkg::*;

    // queue count for a config select code
    function automatic logic [7:0] qcount_of(input logic [1:0] sel, input logic [7:0] prog);
        logic [7:0] r;
        r = prog;
        if (sel == 2'b10)
            r = `MQ_QCNT_64;
        else if (sel == 2'b11)
            r = `MQ_QCNT_128;
        return r;
    endfunction

    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic mrs_active;
    mq_straps_t straps;
    mq_straps_t next_straps;
    logic [7:0] qcount;
    logic [7:0] next_qcount;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [31:0] next_prdata;
    logic [6:0] next_queue;
    logic dev_sel;
    logic next_dev_sel;
    logic [1:0] fall_cnt;
    logic [1:0] next_fall_cnt;
    logic [35:0] next_q_data;
    logic q_valid;
    logic next_q_valid;
    logic next_pr_n;
    logic next_pae_n;
    logic sel_take;
    logic prog_done;
    logic [2:0] device_id;
    logic [31:0] status_word;

    // pin synchroniser: second stage is the only reader of the first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end
        else
        begin
            pin_s1 <= {!master_reset_n, packet_mode_strap, flag_mode_strap, 1'b0};
            pin_s2 <= pin_s1;
        end
    end
    assign pin_s3 = pin_s2;
    assign mrs_active = pin_s3[3];

    assign prog_done = ctrl[`MQ_CTRL_DONE_BIT];
    assign device_id = ctrl[`MQ_CTRL_ID_LSB +: 3];
    assign serial_done_out_n = !prog_done;

    // straps and queue count captured while master reset is held
    always_comb
    begin
        next_straps = straps;
        next_qcount = qcount;
        if (mrs_active)
        begin
            next_straps.pkt_mode = pin_s3[2];
            next_straps.direct_mode = pin_s3[1];
            next_straps.qsel = queue_config_select;
            next_qcount = qcount_of(queue_config_select,
                queue_config_select == 2'b01 ? read_address_bus : ctrl[`MQ_CTRL_QCNT_LSB +: 8]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            straps <= '0;
            qcount <= `MQ_QCNT_128;
        end
        else
        begin
            straps <= next_straps;
            qcount <= next_qcount;
        end
    end

    // apb slave: control write, status read, error on unmapped
    assign status_word = {11'h0, qcount, fall_cnt, q_valid, dev_sel,
        straps.direct_mode, straps.pkt_mode, core_queue};
    always_comb
    begin
        next_ctrl = ctrl;
        next_prdata = prdata;
        if (psel && !penable)
        begin
            next_prdata = 32'h0000_0000;
            if (!pwrite && paddr == `MQ_REG_CTRL)
                next_prdata = ctrl;
            else if (!pwrite && paddr == `MQ_REG_STATUS)
                next_prdata = status_word;
        end
        if (psel && penable && pwrite && paddr == `MQ_REG_CTRL)
            next_ctrl = {20'h0, pwdata[11:0]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `MQ_CTRL_RESET;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            prdata <= next_prdata;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && paddr != `MQ_REG_CTRL && paddr != `MQ_REG_STATUS;

    // queue select accepted only after programming, whatever read enable
    assign sel_take = read_addr_enable && prog_done && !mrs_active;

    // read path: queue switch, fall through and normal reads
    always_comb
    begin
        next_queue = core_queue;
        next_dev_sel = dev_sel;
        next_fall_cnt = fall_cnt;
        next_q_data = q_data;
        next_q_valid = q_valid;
        core_pop = 1'b0;
        if (fall_cnt != 2'h0)
            next_fall_cnt = fall_cnt - 2'h1;
        if (fall_cnt == 2'h1 && dev_sel)
        begin
            next_q_valid = core.head_valid;
            core_pop = core.head_valid;
        end
        else if (fall_cnt == 2'h0 && dev_sel && (!q_valid
            || (!read_enable_n && !read_chip_select_n)))
        begin
            next_q_valid = core.head_valid;
            core_pop = core.head_valid;
        end
        if (core_pop)
        begin
            next_q_data = core.head_data;
            if (straps.pkt_mode)
            begin
                next_q_data[`MQ_SOP_BIT] = core.head_sop;
                next_q_data[`MQ_EOP_BIT] = core.head_eop;
            end
        end
        if (sel_take)
        begin
            next_queue = read_address_bus[`MQ_Q_MSB:0];
            next_dev_sel = read_address_bus[7:`MQ_DEV_LSB] == device_id
                && {1'b0, read_address_bus[`MQ_Q_MSB:0]} < qcount;
            next_fall_cnt = `MQ_FALL_EDGES;
        end
        if (mrs_active)
        begin
            next_dev_sel = 1'b0;
            next_fall_cnt = 2'h0;
            next_q_valid = 1'b0;
        end
        next_pr_n = !(straps.pkt_mode && core.pkt_ready && dev_sel);
        next_pae_n = !(core.almost_empty && dev_sel);
    end

    // read path registers and flags, all on the read clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_queue <= 7'h00;
            dev_sel <= 1'b0;
            fall_cnt <= 2'h0;
            q_data <= 36'h0_0000_0000;
            q_valid <= 1'b0;
            packet_ready_flag_n <= 1'b1;
            almost_empty_flag_n <= 1'b1;
        end
        else
        begin
            core_queue <= next_queue;
            dev_sel <= next_dev_sel;
            fall_cnt <= next_fall_cnt;
            q_data <= next_q_data;
            q_valid <= next_q_valid;
            packet_ready_flag_n <= next_pr_n;
            almost_empty_flag_n <= next_pae_n;
        end
    end

    assign read_side_empty_n = !q_valid;
    assign packet_available = !packet_ready_flag_n && !read_side_empty_n;
    // chip select ignored (outputs off) during master reset
    assign q_oe = !output_enable_n && !read_chip_select_n && dev_sel && !mrs_active;

    mq_flag_bus u_flag_bus
    (
        .pclk(pclk),
        .presetn(presetn),
        .mrs_active(mrs_active),
        .direct_mode(straps.direct_mode),
        .pkt_mode(straps.pkt_mode),
        .empty_flag_strobe(empty_flag_strobe),
        .read_address_bus(read_address_bus),
        .device_id(device_id),
        .pr_vec(pr_vec),
        .pae_vec(pae_vec),
        .read_flag_status_bus(read_flag_status_bus),
        .flag_bus_oe(flag_bus_oe),
        .empty_flag_sync(empty_flag_sync)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_queue_latch: assert property (sel_take |=>
        core_queue == $past(read_address_bus[6:0]))
        else $error("read queue not latched");
    a_fall_two_edges: assert property ((sel_take && read_address_bus[7:5] == device_id
        && {1'b0, read_address_bus[6:0]} < qcount) ##1 (!mrs_active && !sel_take)
        |-> ##1 (core_pop || !core.head_valid))
        else $error("first word not fetched two edges after select");
    a_pr_follows: assert property (straps.pkt_mode && core.pkt_ready && dev_sel
        |=> !packet_ready_flag_n)
        else $error("packet ready flag not asserted");
    a_pr_idle_mode: assert property (!straps.pkt_mode ##1 !straps.pkt_mode
        |-> packet_ready_flag_n)
        else $error("packet ready active in almost empty mode");
    a_strap_hold: assert property (!mrs_active |=> $stable(straps))
        else $error("straps changed outside master reset");
    a_output_gate: assert property (q_oe |-> !read_chip_select_n && !output_enable_n
        && !mrs_active)
        else $error("output enabled without chip select");
    a_no_early_sel: assert property (!prog_done |=> $stable(core_queue))
        else $error("queue changed before programming done");
    a_qcfg_fixed: assert property (mrs_active && queue_config_select == 2'b10
        |=> qcount == 8'h40)
        else $error("config select 10 did not give 64 queues");
    a_avail_mode: assert property (packet_available |-> straps.pkt_mode)
        else $error("packet available outside packet mode");

    c_queue_switch: cover property (sel_take ##2 core_pop);
    c_normal_read: cover property (q_valid && !read_enable_n ##1 core_pop);
    c_packet_seen: cover property (packet_available);

endmodule
`default_nettype wire

// File: tb/mq_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mq_core_model
import mq_pkg::*;
#(parameter int DEPTH = 3)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] core_queue,
    input wire logic core_pop,
    output mq_pkg::mq_core_t core,
    output logic [127:0] pr_vec,
    output logic [127:0] pae_vec
);
    logic [1:0] ptr [128];
    logic [1:0] hp;

    // words already taken from each queue
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ptr <= '{default: 2'h0};
        else if (core_pop)
            ptr[core_queue] <= ptr[core_queue] + 2'h1;
    end

    // one packet per queue; head carries queue and position
    always_comb
    begin
        hp = ptr[core_queue];
        core.head_valid = (hp < DEPTH);
        core.head_data = core.head_valid ? {5'h01, core_queue, 22'h0, hp} : 36'hF_FFFF_FFFF;
        core.head_sop = (hp == 2'h0);
        core.head_eop = (hp == DEPTH - 1);
        core.pkt_ready = (hp == 2'h0);
        core.almost_empty = (hp >= DEPTH - 1);
        for (int i = 0; i < 128; i++)
        begin
            pr_vec[i] = (ptr[i] == 2'h0);
            pae_vec[i] = (ptr[i] >= DEPTH - 1);
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_multiqueue_read_port.sv
`timescale 1ns/1ns
`default_nettype none
module tb_multiqueue_read_port;
    import mq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, read_address_bus, read_flag_status_bus;
    logic [31:0] pwdata, prdata, rd;
    logic master_reset_n, packet_mode_strap, flag_mode_strap, read_addr_enable;
    logic [1:0] queue_config_select;
    logic read_enable_n, read_chip_select_n, output_enable_n, empty_flag_strobe;
    mq_core_t core;
    logic [127:0] pr_vec, pae_vec;
    logic [6:0] core_queue;
    logic [35:0] q_data;
    logic core_pop, q_oe, read_side_empty_n, packet_ready_flag_n, almost_empty_flag_n;
    logic packet_available, serial_done_out_n, flag_bus_oe, empty_flag_sync;
    int err_total, check_count;

    mq_read_port dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .master_reset_n, .packet_mode_strap,
        .flag_mode_strap, .queue_config_select, .read_addr_enable, .read_address_bus,
        .read_enable_n, .read_chip_select_n, .output_enable_n, .empty_flag_strobe,
        .core, .pr_vec, .pae_vec, .core_queue, .core_pop, .q_data, .q_oe,
        .read_side_empty_n, .packet_ready_flag_n, .almost_empty_flag_n,
        .packet_available, .serial_done_out_n, .read_flag_status_bus, .flag_bus_oe,
        .empty_flag_sync);

    mq_core_model core_u (.pclk, .presetn, .core_queue, .core_pop, .core, .pr_vec,
        .pae_vec);

    // free running read clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        check_count++;
        if (s !== x)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, s, x);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // master reset with straps
    task automatic mres(input logic pk, input logic fm, input logic [1:0] qs);
        @(posedge pclk);
        master_reset_n <= 1'b0;
        packet_mode_strap <= pk;
        flag_mode_strap <= fm;
        queue_config_select <= qs;
        read_address_bus <= 8'h10;
        repeat (4) @(posedge pclk);
        master_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // one-cycle queue change; strobe stays low
    task automatic sel(input logic [7:0] a);
        @(posedge pclk);
        read_addr_enable <= 1'b1;
        read_address_bus <= a;
        @(posedge pclk);
        read_addr_enable <= 1'b0;
    endtask

    task automatic strobe(input logic [7:0] a);
        @(posedge pclk);
        empty_flag_strobe <= 1'b1;
        read_address_bus <= a;
        @(posedge pclk);
        empty_flag_strobe <= 1'b0;
    endtask

    task automatic t_reset;
        #1;
        chk(serial_done_out_n, 1'b1);
        chk(packet_ready_flag_n, 1'b1);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        chk({er, rd}, 33'h1_0000_0000);
        sel(8'h03);
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd[10:9], 2'h0);
        $display("reset test done");
    endtask

    task automatic t_qsel;
        logic [7:0] qc;
        apb(1'b1, 8'h00, 32'h0000_0201, rd, er);
        // done output settles after the write edge
        #1;
        chk(serial_done_out_n, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            qc = (c == 0) ? 8'h20 : (c == 1) ? 8'h10 : (c == 2) ? 8'h40 : 8'h80;
            mres(c[0], 1'b0, c[1:0]);
            apb(1'b0, 8'h04, 32'h0, rd, er);
            chk(rd[20:13], qc);
            chk(rd[8:7], {1'b0, c[0]});
            if (c == 2)
            begin
                sel(8'h04);
                repeat (3) @(posedge pclk);
                #1;
                chk(packet_ready_flag_n, 1'b1);
                chk(read_side_empty_n, 1'b0);
            end
        end
        $display("queue config test done");
    endtask

    task automatic t_select;
        sel(8'h25);
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd[9], 1'b0);
        sel(8'h03);
        @(posedge pclk);
        #1;
        chk(read_side_empty_n, 1'b1);
        @(posedge pclk);
        #1;
        chk(read_side_empty_n, 1'b0);
        chk(q_data[31:0], {1'b1, 7'h03, 24'h0});
        chk(q_data[33:32], 2'h1);
        chk({packet_ready_flag_n, packet_available}, 2'h1);
        chk(almost_empty_flag_n, 1'b1);
        // read enable without chip select moves nothing
        @(posedge pclk);
        read_enable_n <= 1'b0;
        read_chip_select_n <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk({q_oe, q_data[1:0]}, 3'h0);
        @(posedge pclk);
        read_chip_select_n <= 1'b0;
        for (int k = 1; k < 3; k++)
        begin
            @(posedge pclk);
            #1;
            chk(q_data[31:0], {1'b1, 7'h03, 22'h0, k[1:0]});
            chk({q_oe, q_data[33:32]}, {1'b1, k == 2, 1'b0});
        end
        @(posedge pclk);
        read_enable_n <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        chk({packet_ready_flag_n, packet_available}, 2'h2);
        // all three words of the queue taken: almost empty
        chk(almost_empty_flag_n, 1'b0);
        $display("queue select test done");
    endtask

    task automatic t_flags;
        int n;
        n = 0;
        while (empty_flag_sync !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(read_flag_status_bus, 8'h18);
        repeat (4) @(posedge pclk);
        #1;
        chk(empty_flag_sync, 1'b1);
        @(posedge pclk);
        #1;
        chk({empty_flag_sync, read_flag_status_bus}, 9'h0);
        $display("polled flag test done");
    endtask

    task automatic t_direct;
        mres(1'b1, 1'b1, 2'h3);
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd[8], 1'b1);
        strobe(8'h1C);
        #1;
        chk(flag_bus_oe, 1'b1);
        repeat (3) @(posedge pclk);
        #1;
        chk(read_flag_status_bus, 8'h18);
        strobe(8'h3C);
        #1;
        chk(flag_bus_oe, 1'b0);
        $display("direct flag test done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {packet_mode_strap, flag_mode_strap, queue_config_select} = '0;
        {read_addr_enable, read_address_bus, empty_flag_strobe, output_enable_n} = '0;
        {master_reset_n, read_enable_n, read_chip_select_n} = 3'h7;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        read_chip_select_n <= 1'b0;
        t_reset;
        t_qsel;
        t_select;
        t_flags;
        t_direct;
        complete_run;
    end

    // hang guard
    initial
    begin
        #200000;
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
